//--- tpso_pkg.sv
/*
 * Shared constants and carriers for the trace port status/packet output
 * stage. Assumes one core clock; no software-visible registers.
 */
package tpso_pkg;

    // Pipeline status codes
    localparam logic [3:0] ST_EXEC    = 4'h0;
    localparam logic [3:0] ST_EXEC_D  = 4'h1;
    localparam logic [3:0] ST_NEXEC   = 4'h2;
    localparam logic [3:0] ST_NEXEC_D = 4'h3;
    localparam logic [3:0] ST_WAIT    = 4'h4;
    localparam logic [3:0] ST_WAIT_D  = 4'h5;
    localparam logic [3:0] ST_TRIG    = 4'h6;
    localparam logic [3:0] ST_TDIS    = 4'h7;
    localparam logic       ST_FOLD    = 1'h1; // Bit 3 of folded codes

    // Packet bus layout
    localparam int         PKT_W      = 16;
    localparam int         BYTE_W     = 8;
    localparam int         CBIT       = 7;    // Continue bit of a header
    localparam logic [7:0] FILLER     = 8'h66;
    localparam int         OFS_W      = 6;
    localparam int         FIFO_DEPTH = 4;

    // Reset values
    localparam logic [3:0]       RST_STATUS = ST_TDIS;
    localparam logic [PKT_W-1:0] RST_PKT    = 16'h0000;

    typedef enum logic [1:0] {TPSO_W4, TPSO_W8, TPSO_W16} tpso_width_e;

    typedef enum logic [1:0] {OFS_IDLE, OFS_LO, OFS_HI, OFS_GAP} tpso_ofs_e;

    // One byte entering the trace FIFO
    typedef struct packed {
        logic [7:0] data;
        logic       hdr;    // First byte of a non-branch packet
        logic       more;   // Another packet from this cycle follows
        logic       branch; // Byte of a branch address packet
        logic       first;  // First byte of this cycle's group
    } tpso_byte_s;

    // Core pipeline view for one cycle
    typedef struct packed {
        logic instr;
        logic exec;
        logic fold;
        logic fold_taken;
        logic mispredict;
        logic data_abort;
        logic cancelled;
        logic drop_fetch;
        logic mem_wait;
        logic multi_cycle;
    } tpso_core_s;

endpackage : tpso_pkg

//--- tpso_trace_out.sv
/*
 * Trace FIFO and trace port output stage: status code every cycle, packet
 * bytes drained onto a 4, 8 or 16 pin bus. Assumes the packet source
 * presents one byte per cycle and the port width is static while tracing.
 */
`timescale 1ns/1ns

// Byte FIFO with first-word fall-through and a second read lane
module tpso_fifo
    import tpso_pkg::*;
#(
    parameter int W = 12,
    parameter int D = 4
) (
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data,
    output logic              out2_valid,
    input  wire logic         out2_ready,
    output logic      [W-1:0] out2_data,
    output logic              full,
    output logic              empty
);
    localparam int PW = $clog2(D);
    localparam int CW = $clog2(D + 1);

    logic [W-1:0]  mem_r [D];
    logic [PW-1:0] wr_r;
    logic [PW-1:0] rd_r;
    logic [CW-1:0] cnt_r;
    logic          push;
    logic          pop1;
    logic          pop2;
    logic [CW-1:0] pops;

    // Empty FIFO passes the input straight through, so no cycle is lost
    assign empty      = (cnt_r == '0);
    assign full       = (cnt_r == CW'(D));
    assign in_ready   = !full;
    assign push       = in_valid && in_ready;
    assign out_valid  = !empty || in_valid;
    assign out_data   = empty ? in_data : mem_r[rd_r];
    assign out2_valid = (cnt_r >= CW'(2)) || (cnt_r == CW'(1) && in_valid);
    assign out2_data  = (cnt_r >= CW'(2)) ? mem_r[PW'(rd_r + 1'b1)] : in_data;
    assign pop1       = out_valid && out_ready;
    assign pop2       = pop1 && out2_valid && out2_ready;
    assign pops       = CW'(pop1) + CW'(pop2);

    // Storage; a bypassed byte is written and skipped in the same edge
    always_ff @(posedge clock) begin
        if (push) begin
            mem_r[wr_r] <= in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clock) begin
        if (rst) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else begin
            wr_r  <= PW'(wr_r + PW'(push));
            rd_r  <= PW'(rd_r + PW'(pops));
            cnt_r <= CW'(cnt_r + CW'(push) - pops);
        end
    end
endmodule : tpso_fifo

module tpso_trace_out
    import tpso_pkg::*;
(
    input  wire logic             clock,
    input  wire logic             rst,
    input  tpso_width_e           port_width,
    input  wire logic             trace_en,
    input  tpso_core_s            core,
    input  wire logic             trigger,
    input  wire logic             ofs_req,
    input  wire logic [OFS_W-1:0] ofs_val,
    input  wire logic             pkt_valid,
    output logic                  pkt_ready,
    input  tpso_byte_s            pkt_in,
    output logic [3:0]            pipeline_status,
    output logic [PKT_W-1:0]      trace_packet_bus
);
    localparam int EW = $bits(tpso_byte_s);

    tpso_byte_s       fin;
    tpso_byte_s       hd;
    tpso_byte_s       hd2;
    logic             f_hv;
    logic             f_h2v;
    logic             f_pop;
    logic             f_pop2;
    logic             f_empty;
    logic             with_data;
    logic             exec_eff;
    logic             waiting;
    logic             drain;
    logic             ofs_start;
    logic             ofs_act;
    logic             ofs_pend_r;
    logic [OFS_W-1:0] ofs_val_r;
    tpso_ofs_e        ofs_st_r;
    tpso_ofs_e        ofs_st_nxt;
    tpso_ofs_e        ofs_emit;
    logic             nib_r;
    logic             nib_nxt;
    logic [3:0]       base;
    logic [3:0]       status_r;
    logic [3:0]       status_nxt;
    logic [PKT_W-1:0] pkt_r;
    logic [PKT_W-1:0] pkt_nxt;
    logic [7:0]       hd_q;

    // Continue bit is forced from the source's framing flag
    always_comb begin
        fin = pkt_in;
        if (pkt_in.hdr) begin
            fin.data[CBIT] = pkt_in.more;
        end
    end

    tpso_fifo #(
        .W (EW),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .clock      (clock),
        .rst        (rst),
        .in_valid   (pkt_valid),
        .in_ready   (pkt_ready),
        .in_data    (fin),
        .out_valid  (f_hv),
        .out_ready  (f_pop),
        .out_data   (hd),
        .out2_valid (f_h2v),
        .out2_ready (f_pop2),
        .out2_data  (hd2),
        .full       (),
        .empty      (f_empty)
    );

    // A group's first byte accepted marks this cycle as with-data
    assign with_data = pkt_valid && pkt_ready && pkt_in.first;
    assign exec_eff  = core.exec || core.data_abort;
    assign waiting   = core.drop_fetch || core.mem_wait || core.multi_cycle;

    // Offset output starts only on a byte boundary and never under a trigger
    assign ofs_start = ofs_pend_r && ofs_st_r == OFS_IDLE && !nib_r && !trigger;
    assign ofs_emit  = ofs_start ? OFS_LO : ofs_st_r;
    assign ofs_act   = ofs_emit != OFS_IDLE;
    assign drain     = !trigger && !ofs_act;

    // Status the core cycle would give without a trigger or offset
    always_comb begin
        if (trace_en && core.instr) begin
            // First executing cycle is the only one flagged by the core
            // Cancelled instructions keep whatever outcome the core gave
            if (core.fold && !core.mispredict) begin
                base = {ST_FOLD, !core.fold_taken, !exec_eff, with_data};
            end else if (core.fold) begin
                base = {2'b00, !core.fold_taken, with_data};
            end else begin
                base = {2'b00, !exec_eff, with_data};
            end
        end else if (with_data) begin
            base = ST_WAIT_D;
        end else if (f_hv || nib_r || waiting) begin
            base = ST_WAIT;
        end else begin
            base = ST_TDIS;
        end
    end

    // Next status and pins, with pops and nibble phase
    always_comb begin
        status_nxt = base;
        pkt_nxt    = '0; // Idle trace-disabled keeps bit 0 low
        f_pop      = 1'b0;
        f_pop2     = 1'b0;
        nib_nxt    = nib_r;
        ofs_st_nxt = ofs_st_r;
        if (trigger) begin
            // Trigger is never held back, so it may lead its cause
            status_nxt = ST_TRIG;
            if (ofs_pend_r || ofs_st_r != OFS_IDLE) begin
                pkt_nxt[3:0] = ST_TDIS;
            end else if (base == ST_TDIS) begin
                pkt_nxt[3:0] = ST_WAIT;
            end else begin
                pkt_nxt[3:0] = base;
            end
        end else if (ofs_act) begin
            status_nxt = ST_TDIS;
            unique case (ofs_emit)
                OFS_LO: begin
                    pkt_nxt[0] = 1'b1;
                    if (port_width == TPSO_W4) begin
                        pkt_nxt[3:1] = ofs_val_r[2:0];
                        ofs_st_nxt   = OFS_HI;
                    end else begin
                        pkt_nxt[OFS_W:1] = ofs_val_r;
                        ofs_st_nxt       = OFS_IDLE;
                    end
                end
                OFS_HI: begin
                    pkt_nxt[0]   = 1'b1;
                    pkt_nxt[3:1] = ofs_val_r[5:3];
                    ofs_st_nxt   = OFS_GAP;
                end
                OFS_GAP: begin
                    ofs_st_nxt = OFS_IDLE;
                end
                OFS_IDLE: begin
                    ofs_st_nxt = OFS_IDLE;
                end
            endcase
        end else if (f_hv) begin
            // Drain every cycle there is data, so groups abut
            unique case (port_width)
                TPSO_W4: begin
                    if (nib_r) begin
                        pkt_nxt[3:0] = hd.data[7:4];
                        f_pop        = 1'b1;
                        nib_nxt      = 1'b0;
                    end else begin
                        pkt_nxt[3:0] = hd.data[3:0];
                        nib_nxt      = 1'b1;
                    end
                end
                TPSO_W8: begin
                    pkt_nxt[7:0] = hd.data;
                    f_pop        = 1'b1;
                end
                TPSO_W16: begin
                    pkt_nxt[7:0] = hd.data;
                    f_pop        = 1'b1;
                    f_pop2       = f_h2v;
                    pkt_nxt[15:8] = f_h2v ? hd2.data : FILLER;
                end
                default: begin
                    pkt_nxt = '0;
                end
            endcase
        end
    end

    // Offset request latch; a new request wins over the start
    always_ff @(posedge clock) begin
        if (rst) begin
            ofs_pend_r <= 1'b0;
            ofs_val_r  <= '0;
        end else if (ofs_req) begin
            ofs_pend_r <= 1'b1;
            ofs_val_r  <= ofs_val;
        end else if (ofs_start) begin
            ofs_pend_r <= 1'b0;
        end
    end

    // Offset sequence holds under a trigger, slipping one cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            ofs_st_r <= OFS_IDLE;
            nib_r    <= 1'b0;
        end else if (!trigger) begin
            ofs_st_r <= ofs_st_nxt;
            nib_r    <= nib_nxt;
        end
    end

    // Registered pins; reset shows trace disabled with a quiet bus
    always_ff @(posedge clock) begin
        if (rst) begin
            status_r <= RST_STATUS;
            pkt_r    <= RST_PKT;
        end else begin
            status_r <= status_nxt;
            pkt_r    <= pkt_nxt;
        end
    end

    assign pipeline_status  = status_r;
    assign trace_packet_bus = pkt_r;

    // Head byte one cycle back, for the checks below
    always_ff @(posedge clock) begin
        hd_q <= hd.data;
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    property p_wd;
        with_data && drain |=> pipeline_status[0] && pipeline_status != ST_TDIS;
    endproperty
    a_wd: assert property (p_wd) else $error("with-data cycle lost its data code");

    property p_abort;
        trace_en && core.instr && core.data_abort && !core.fold && drain
            |=> pipeline_status[3:1] == 3'b000;
    endproperty
    a_abort: assert property (p_abort) else $error("aborted load shown not executed");

    property p_trig;
        trigger |=> pipeline_status == ST_TRIG && trace_packet_bus[3:0] != ST_TRIG;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger not shown at once");

    property p_hold;
        trigger && f_hv && !f_empty |=> hd.data == hd_q;
    endproperty
    a_hold: assert property (p_hold) else $error("FIFO drained in trigger cycle");

    property p_td;
        f_hv && drain |=> pipeline_status != ST_TDIS;
    endproperty
    a_td: assert property (p_td) else $error("trace disabled with data queued");

    property p_fill;
        port_width == TPSO_W16 && f_hv && !f_h2v && drain
            |=> trace_packet_bus[15:8] == FILLER;
    endproperty
    a_fill: assert property (p_fill) else $error("upper lane not filler");

    sequence s_lo_start;
        drain && port_width == TPSO_W4 && f_hv && !nib_r;
    endsequence
    sequence s_hi_go;
        drain && nib_r;
    endsequence

    property p_lo;
        s_lo_start |=> trace_packet_bus[3:0] == hd_q[3:0];
    endproperty
    a_lo: assert property (p_lo) else $error("low nibble not first");

    property p_hi;
        s_lo_start ##1 s_hi_go |=> trace_packet_bus[3:0] == hd_q[7:4];
    endproperty
    a_hi: assert property (p_hi) else $error("high nibble not second");

    property p_bypass;
        with_data && f_empty && port_width == TPSO_W8 && drain
            |=> trace_packet_bus[7:0] == hd_q;
    endproperty
    a_bypass: assert property (p_bypass) else $error("group late on empty FIFO");

    property p_ofs;
        ofs_start && port_width == TPSO_W4 ##1 !trigger
            |=> pipeline_status == ST_TDIS && trace_packet_bus[0] ##1
                pipeline_status == ST_TDIS || pipeline_status == ST_TRIG;
    endproperty
    a_ofs: assert property (p_ofs) else $error("offset nibbles malformed");

    property p_trig_td;
        trigger && (ofs_pend_r || ofs_st_r != OFS_IDLE) |=> trace_packet_bus[3:0] == ST_TDIS;
    endproperty
    a_trig_td: assert property (p_trig_td) else $error("trigger hid a pending offset");

    property p_nogap;
        port_width == TPSO_W8 && f_hv && drain |-> f_pop;
    endproperty
    a_nogap: assert property (p_nogap) else $error("idle gap with data queued");

    property p_rst;
        @(posedge clock) disable iff (1'b0)
            rst |=> pipeline_status == ST_TDIS && trace_packet_bus == RST_PKT;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");

endmodule : tpso_trace_out

//--- tpso_capture.sv
/*
 * Behavioural trace capture device on the far side of the trace port.
 * Assumes status and packet pins are sampled on the rising core clock edge.
 */
`timescale 1ns/1ns

module tpso_capture
    import tpso_pkg::*;
(
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [3:0]       pipeline_status,
    input  wire logic [PKT_W-1:0] trace_packet_bus,
    output logic      [7:0]       n_ofs_r
);
    logic tdis;

    // Disabled cycles with bit 0 low carry nothing and are dropped
    assign tdis = (pipeline_status == ST_TDIS);

    // Offset cycles recognised only by bit 0 of a disabled cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            n_ofs_r <= 8'h00;
        end else if (tdis && trace_packet_bus[0]) begin
            n_ofs_r <= n_ofs_r + 8'h01;
        end
    end
endmodule : tpso_capture

//--- test_tpso_trace_out.sv
/*
 * Self-checking bench for the trace output stage, capture model on the pins.
 * Assumes tpso_pkg, tpso_trace_out and tpso_capture are compiled first.
 */
`timescale 1ns/1ns

module test_tpso_trace_out
    import tpso_pkg::*;
;
    logic             clock;
    logic             rst;
    tpso_width_e      port_width;
    logic             trace_en;
    tpso_core_s       core;
    logic             trigger;
    logic             ofs_req;
    logic [OFS_W-1:0] ofs_val;
    logic             pkt_valid;
    logic             pkt_ready;
    tpso_byte_s       pkt_in;
    logic [3:0]       pipeline_status;
    logic [PKT_W-1:0] trace_packet_bus;
    logic [7:0]       n_ofs_r;
    tpso_width_e      wsel;
    logic             ten;
    logic [OFS_W-1:0] ov;
    int               mismatches;
    int               n_tests;

    // Core views: instr, exec, fold, taken, mispredict, abort, cancel, drop, wait, multi
    localparam logic [9:0] IDLE = 10'h000;
    localparam logic [9:0] EXE  = 10'h300;
    localparam logic [9:0] NEX  = 10'h200;

    tpso_trace_out u_tpso_trace_out (.clock(clock), .rst(rst), .port_width(port_width),
        .trace_en(trace_en), .core(core), .trigger(trigger), .ofs_req(ofs_req),
        .ofs_val(ofs_val), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready), .pkt_in(pkt_in),
        .pipeline_status(pipeline_status), .trace_packet_bus(trace_packet_bus));

    tpso_capture u_tpso_capture (.clock(clock), .rst(rst), .pipeline_status(pipeline_status),
        .trace_packet_bus(trace_packet_bus), .n_ofs_r(n_ofs_r));

    // Free-running core clock, 40 ns period
    always #20 clock = ~clock;

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude

    task automatic chk_st(input logic [3:0] want);
        n_tests++;
        if (pipeline_status !== want) begin
            mismatches++;
            $display("[FAIL] %0t status %h expected %h", $time, pipeline_status, want);
        end
    endtask : chk_st

    task automatic chk_bus(input logic [PKT_W-1:0] mask, input logic [PKT_W-1:0] want);
        n_tests++;
        if ((trace_packet_bus & mask) !== (want & mask)) begin
            mismatches++;
            $display("[FAIL] %0t bus %h expected %h", $time, trace_packet_bus, want);
        end
    endtask : chk_bus

    task automatic chk_val(input logic [15:0] got, input logic [15:0] want);
        n_tests++;
        if (got !== want) begin
            mismatches++;
            $display("[FAIL] %0t value %h expected %h", $time, got, want);
        end
    endtask : chk_val

    // One cycle of stimulus; on return the previous cycle's outputs are settled
    task automatic tick(input logic [9:0] c, input logic tg = 1'b0, input logic v = 1'b0,
                        input logic [7:0] d = 8'h00, input logic oq = 1'b0,
                        input logic [1:0] hm = 2'b00);
        @(posedge clock);
        port_width <= wsel;
        trace_en   <= ten;
        core       <= tpso_core_s'(c);
        trigger    <= tg;
        pkt_valid  <= v;
        pkt_in     <= tpso_byte_s'({d, hm, 1'b0, v});
        ofs_req    <= oq;
        ofs_val    <= ov;
        #1;
    endtask : tick

    // Bounded wait for the first offset cycle on the pins
    task automatic wait_ofs();
        int i;
        for (i = 0; i < 8; i++) begin
            if (pipeline_status === ST_TDIS && trace_packet_bus[0] === 1'b1) break;
            tick(IDLE);
        end
        if (i == 8) begin
            mismatches++;
            $display("[FAIL] %0t offset never appeared", $time);
            conclude();
        end
    endtask : wait_ofs

    task automatic sc_status();
        logic [9:0] cin [11] = '{EXE, NEX, 10'h210, 10'h208, 10'h002, 10'h004, 10'h001,
                                 10'h3c0, 10'h380, 10'h3e0, IDLE};
        logic [3:0] want [11] = '{ST_EXEC, ST_NEXEC, ST_EXEC, ST_NEXEC, ST_WAIT, ST_WAIT,
                                  ST_WAIT, 4'h8, 4'hc, ST_EXEC, ST_TDIS};
        for (int i = 0; i <= 11; i++) begin
            tick(i < 11 ? cin[i] : IDLE);
            if (i > 0) chk_st(want[i-1]);
        end
        ten = 1'b0;
        tick(EXE);
        ten = 1'b1;
        tick(IDLE);
        chk_st(ST_TDIS);
    endtask : sc_status

    // Groups back to back on eight pins, each with its own data status
    task automatic sc_data();
        wsel = TPSO_W8;
        tick(EXE, 1'b0, 1'b1, 8'hab);
        tick(NEX, 1'b0, 1'b1, 8'h3c);
        chk_st(ST_EXEC_D);
        chk_bus(16'h00ff, 16'h00ab);
        tick(IDLE, 1'b0, 1'b1, 8'h5a);
        chk_st(ST_NEXEC_D);
        chk_bus(16'h00ff, 16'h003c);
        tick(IDLE);
        chk_st(ST_WAIT_D);
        chk_bus(16'h00ff, 16'h005a);
        tick(IDLE);
        chk_st(ST_TDIS);
        chk_bus(16'h0001, 16'h0000);
    endtask : sc_data

    // Header continue bit follows the framing flag, whatever the source put there
    task automatic sc_hdr();
        wsel = TPSO_W8;
        tick(EXE, 1'b0, 1'b1, 8'h02, 1'b0, 2'b11);
        tick(IDLE, 1'b0, 1'b1, 8'h82, 1'b0, 2'b10);
        chk_st(ST_EXEC_D);
        chk_bus(16'h00ff, 16'h0082);
        tick(IDLE);
        chk_bus(16'h00ff, 16'h0002);
        tick(IDLE);
    endtask : sc_hdr

    task automatic sc_w4();
        wsel = TPSO_W4;
        tick(EXE, 1'b0, 1'b1, 8'hc9);
        tick(IDLE);
        chk_st(ST_EXEC_D);
        chk_bus(16'h000f, 16'h0009);
        tick(IDLE);
        chk_st(ST_WAIT);
        chk_bus(16'h000f, 16'h000c);
        tick(IDLE);
        chk_st(ST_TDIS);
    endtask : sc_w4

    // Triggers on empty and busy cycles, then two queued bytes on sixteen pins
    task automatic sc_trig16();
        wsel = TPSO_W16;
        tick(IDLE, 1'b1);
        tick(EXE, 1'b1);
        chk_st(ST_TRIG);
        chk_bus(16'h000f, {12'h000, ST_WAIT});
        tick(IDLE, 1'b1, 1'b1, 8'h12);
        chk_st(ST_TRIG);
        chk_bus(16'h000f, {12'h000, ST_EXEC});
        tick(IDLE, 1'b1, 1'b1, 8'h34);
        tick(IDLE);
        tick(IDLE);
        chk_st(ST_WAIT);
        chk_bus(16'hffff, 16'h3412);
        tick(EXE, 1'b0, 1'b1, 8'h77);
        tick(IDLE);
        chk_st(ST_EXEC_D);
        chk_bus(16'hffff, {FILLER, 8'h77});
    endtask : sc_trig16

    // Triggers freeze the drain until the FIFO refuses, then it empties in order
    task automatic sc_full();
        wsel = TPSO_W8;
        for (int i = 0; i <= 4; i++) begin
            tick(IDLE, 1'b1, i < 4, 8'ha0 + 8'(i));
            if (i > 0) chk_bus(16'h000f, {12'h000, ST_WAIT_D});
        end
        chk_val({15'h0000, pkt_ready}, 16'h0000);
        tick(IDLE);
        chk_st(ST_TRIG);
        chk_bus(16'h000f, {12'h000, ST_WAIT});
        for (int i = 0; i < 4; i++) begin
            tick(IDLE);
            chk_st(ST_WAIT);
            chk_bus(16'h00ff, {8'h00, 8'ha0 + 8'(i)});
        end
        tick(IDLE);
        chk_st(ST_TDIS);
        chk_val({15'h0000, pkt_ready}, 16'h0001);
    endtask : sc_full

    // Offset output, optionally with triggers while pending and in the gap
    task automatic sc_ofs(input tpso_width_e w, input logic [5:0] v, input logic tm);
        wsel = w;
        ov = v;
        tick(IDLE, 1'b0, 1'b0, 8'h00, 1'b1);
        tick(IDLE, tm);
        if (tm) begin
            tick(IDLE);
            chk_st(ST_TRIG);
            chk_bus(16'h000f, {12'h000, ST_TDIS});
        end
        wait_ofs();
        if (w == TPSO_W4) begin
            chk_bus(16'h000f, {12'h000, v[2:0], 1'b1});
            tick(IDLE, tm);
            chk_st(ST_TDIS);
            chk_bus(16'h000f, {12'h000, v[5:3], 1'b1});
            if (tm) begin
                tick(IDLE);
                chk_st(ST_TRIG);
                chk_bus(16'h000f, {12'h000, ST_TDIS});
            end
            tick(IDLE);
            chk_st(ST_TDIS);
            chk_bus(16'h000f, 16'h0000);
        end else begin
            chk_bus(16'h007f, {9'h000, v, 1'b1});
        end
        tick(IDLE);
    endtask : sc_ofs

    initial begin
        clock = 1'b0;
        rst = 1'b1;
        port_width = TPSO_W8;
        trace_en = 1'b1;
        core = '0;
        trigger = 1'b0;
        ofs_req = 1'b0;
        ofs_val = '0;
        pkt_valid = 1'b0;
        pkt_in = '0;
        wsel = TPSO_W8;
        ten = 1'b1;
        ov = '0;
        mismatches = 0;
        n_tests = 0;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        #1;
        chk_st(RST_STATUS);
        chk_bus(16'hffff, RST_PKT);
        sc_status();
        sc_data();
        sc_hdr();
        sc_w4();
        sc_trig16();
        sc_full();
        sc_ofs(TPSO_W8, 6'h2d, 1'b1);
        sc_ofs(TPSO_W4, 6'h1a, 1'b0);
        sc_ofs(TPSO_W4, 6'h35, 1'b1);
        chk_val({8'h00, n_ofs_r}, 16'h0005);
        conclude();
    end
endmodule : test_tpso_trace_out
